// file: rtl/ddf_regs.svh
// Constants for the double data rate memory front end
`ifndef DDF_REGS_SVH
`define DDF_REGS_SVH

// Mode word fields, loaded by a mode set with bank address 0
`define DDF_MR_BL_LSB 0
`define DDF_MR_BT_BIT 3
`define DDF_MR_CL_LSB 4
`define DDF_MR_BANK 2'h0

// Burst length codes
`define DDF_BL_CODE_2 3'h1
`define DDF_BL_CODE_4 3'h2
`define DDF_BL_CODE_8 3'h3

// Read latency codes
`define DDF_CL_CODE_2 3'h2
`define DDF_CL_CODE_25 3'h6
`define DDF_CL_CODE_3 3'h3
`define DDF_CL_CODE_4 3'h4

// Address bit that widens a precharge to all banks
`define DDF_PRE_ALL_BIT 10

// Mode reset values: burst of four, sequential, latency two
`define DDF_RST_BL_WORDS 3'h2
`define DDF_RST_CL_TAP 2'h0
`define DDF_RST_CL_HALF 1'h0
`define DDF_RST_IL 1'h0

// Depth of the read latency delay line, in link clocks
`define DDF_RD_DLY_DEPTH 3

// Self refresh timing
`define DDF_MCLK_PERIOD_NS 4
`define DDF_REF_ROWS 8192
`define DDF_REF_ROW_W 13
`define DDF_REF_PERIOD_MS 64
`define DDF_REF_INTERVAL_CYC ((`DDF_REF_PERIOD_MS * 1000000) / (`DDF_REF_ROWS * `DDF_MCLK_PERIOD_NS))

`endif

// file: rtl/ddf_pkg.sv
// Types shared by the memory front end
package ddf_pkg;

    typedef enum logic [2:0] {
        DDF_CMD_NOP,
        DDF_CMD_ACT,
        DDF_CMD_READ,
        DDF_CMD_WRITE,
        DDF_CMD_PRE,
        DDF_CMD_REF,
        DDF_CMD_MRS,
        DDF_CMD_STOP
    } ddf_cmd_type;

    typedef enum logic [1:0] {
        DDF_PWR_ON,
        DDF_PWR_PDN_PRE,
        DDF_PWR_PDN_ACT,
        DDF_PWR_SREF
    } ddf_pwr_type;

    typedef logic [1:0] ddf_bank_type;

endpackage : ddf_pkg

// file: rtl/ddf_mem.sv
// Two-port byte-enabled storage with registered read data
`timescale 1ns/1ns
module ddf_mem #(
    parameter int AW = 13,
    parameter int LANES = 2
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [8*LANES-1:0] wr_data,
    input wire logic [LANES-1:0] wr_be,
    // Read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [8*LANES-1:0] rd_data
);
    logic [8*LANES-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_en && wr_be[i]) begin
                mem[wr_addr][8*i +: 8] <= wr_data[8*i +: 8];
            end
        end
    end

    // A read of an address being written returns the old word
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : ddf_mem

// file: rtl/ddf_frontend.sv
// Double data rate memory front end: command, banks, data, power states
// Functional notes
// - Commands and addresses are taken only on the rising link clock edge.
// - Write data and masks are captured on both link clock edges.
// - Read data leaves on both clock edges, one beat per half clock.
// - Each column access fetches two beats, sent on consecutive half clocks.
// - Read latency is selectable as 2, 2.5, 3 or 4 clocks.
// - Burst of 2, 4 or 8 beats, sequential or interleaved order.
// - Four banks, each opened by a single activate command.
// - Auto refresh by command; self refresh timed internally, 8192 per 64 ms.
// - Clock enable high admits commands, advances bursts and enables drivers; low stops these, data capture runs on.
// - Enable drop: idle banks give power-down or self refresh, else active.
// - Clock enable is sampled on clock edges for power-down and refresh entry.
// - Self refresh exit and output disable follow clock enable directly.
// - In power-down only clock and clock enable are heeded.
// - In self refresh only clock enable is heeded.
// - Chip select high masks commands; data and mask capture ignore it.
// - Chip select is one bit of the command code.
// - Read data aligns with strobe edges; write data is centred on them.
// - Output data and strobe transitions follow the input clock transitions.
// - The mask is taken on both edges, masking each beat separately.
// - Each byte lane has its own strobe, two for a sixteen-bit bus.
// - A beat whose mask is high is not written.
// - Bank address selects the bank for activate, read, write, precharge.
// - Precharge closes one bank with address bit 10 low, all when high.
// - Command decoded from row, column and write strobes with chip select.
`timescale 1ns/1ns
`include "ddf_regs.svh"
module ddf_frontend #(
    parameter int DQ_W = 8,
    parameter int ROW_W = 13,
    parameter int COL_W = 10,
    parameter int ROW_KEEP = 2
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link clock, enable and command
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire ddf_pkg::ddf_bank_type ba,
    input wire logic [ROW_W-1:0] addr,
    // Data, strobes and masks
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [DQ_W/8-1:0] dqs_in,
    output logic [DQ_W/8-1:0] dqs_out,
    output logic [DQ_W/8-1:0] dqs_oe_n,
    input wire logic [DQ_W/8-1:0] dm,
    // Status on the link clock
    output ddf_pkg::ddf_pwr_type power_state,
    output logic self_refresh,
    output logic [3:0] bank_open,
    output logic [`DDF_REF_ROW_W-1:0] auto_ref_row,
    output logic [DQ_W/8-1:0] wr_dqs_toggle,
    // Status on the system clock
    output logic sref_refresh,
    output logic [`DDF_REF_ROW_W-1:0] sref_row
);
    import ddf_pkg::*;

    localparam int LANES = DQ_W / 8;
    localparam int CW = COL_W - 1;
    localparam int AW = 2 + ROW_KEEP + CW;
    localparam int DLY = `DDF_RD_DLY_DEPTH;
    localparam int REF_CNT = `DDF_REF_INTERVAL_CYC;
    localparam int TW = $clog2(REF_CNT + 1);

    function automatic ddf_cmd_type ddf_decode(input logic [3:0] code);
        ddf_cmd_type c;
        c = DDF_CMD_NOP;
        unique casez (code)
            4'b1???: c = DDF_CMD_NOP;
            4'b0111: c = DDF_CMD_NOP;
            4'b0011: c = DDF_CMD_ACT;
            4'b0101: c = DDF_CMD_READ;
            4'b0100: c = DDF_CMD_WRITE;
            4'b0110: c = DDF_CMD_STOP;
            4'b0010: c = DDF_CMD_PRE;
            4'b0001: c = DDF_CMD_REF;
            4'b0000: c = DDF_CMD_MRS;
        endcase
        return c;
    endfunction : ddf_decode

    function automatic logic [1:0] ddf_burst_word(input logic [1:0] start,
                                                  input logic [1:0] j,
                                                  input logic [2:0] words,
                                                  input logic il);
        logic [1:0] mask;
        mask = 2'(words - 3'h1);
        if (il) begin
            return (start & ~mask) | ((start ^ j) & mask);
        end
        return (start & ~mask) | (2'(start + j) & mask);
    endfunction : ddf_burst_word

    // Reset carried into the link domain; needs running link clock edges
    logic rst_meta;
    logic ck_rst;
    always_ff @(posedge ck) begin
        rst_meta <= sys_rst;
        ck_rst <= rst_meta;
    end

    ddf_cmd_type cmd;
    ddf_pwr_type pwr;
    logic cke_q;
    logic accept;
    logic all_idle;
    logic sref_flag;

    assign cmd = ddf_decode({cs_n, ras_n, cas_n, we_n});
    // Commands need enable high at this and the previous edge
    assign accept = (pwr == DDF_PWR_ON) && cke_q && cke && !ck_rst;
    assign all_idle = (bank_open == 4'h0);

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= cke;
        end
    end

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            pwr <= DDF_PWR_ON;
            sref_flag <= 1'b0;
        end else begin
            unique case (pwr)
                DDF_PWR_ON: begin
                    if (cke_q && !cke) begin
                        if (all_idle && cmd == DDF_CMD_REF) begin
                            pwr <= DDF_PWR_SREF;
                            sref_flag <= 1'b1;
                        end else if (all_idle) begin
                            pwr <= DDF_PWR_PDN_PRE;
                        end else begin
                            pwr <= DDF_PWR_PDN_ACT;
                        end
                    end
                end
                DDF_PWR_PDN_PRE, DDF_PWR_PDN_ACT: begin
                    if (cke) begin
                        pwr <= DDF_PWR_ON;
                    end
                end
                DDF_PWR_SREF: begin
                    if (cke) begin
                        pwr <= DDF_PWR_ON;
                        sref_flag <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign power_state = pwr;
    // Exit shows at once, before any link clock edge arrives
    assign self_refresh = sref_flag && !cke;

    // Bank state
    logic [ROW_W-1:0] bank_row [0:3];
    always_ff @(posedge ck) begin
        for (int b = 0; b < 4; b++) begin
            if (ck_rst) begin
                bank_open[b] <= 1'b0;
                bank_row[b] <= '0;
            end else if (accept && cmd == DDF_CMD_ACT && ba == 2'(b)) begin
                bank_open[b] <= 1'b1;
                bank_row[b] <= addr;
            end else if (accept && cmd == DDF_CMD_PRE &&
                         (addr[`DDF_PRE_ALL_BIT] || ba == 2'(b))) begin
                bank_open[b] <= 1'b0;
            end
        end
    end

    // Mode settings
    logic [2:0] bl_words;
    logic il;
    logic [1:0] cl_tap;
    logic cl_half;
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    assign bl_code = addr[`DDF_MR_BL_LSB +: 3];
    assign cl_code = addr[`DDF_MR_CL_LSB +: 3];

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            bl_words <= `DDF_RST_BL_WORDS;
            il <= `DDF_RST_IL;
            cl_tap <= `DDF_RST_CL_TAP;
            cl_half <= `DDF_RST_CL_HALF;
        end else if (accept && cmd == DDF_CMD_MRS && ba == `DDF_MR_BANK) begin
            il <= addr[`DDF_MR_BT_BIT];
            // Unlisted codes leave the old setting in place
            unique case (bl_code)
                `DDF_BL_CODE_2: bl_words <= 3'h1;
                `DDF_BL_CODE_4: bl_words <= 3'h2;
                `DDF_BL_CODE_8: bl_words <= 3'h4;
                default: bl_words <= bl_words;
            endcase
            unique case (cl_code)
                `DDF_CL_CODE_2: begin
                    cl_tap <= 2'h0;
                    cl_half <= 1'b0;
                end
                `DDF_CL_CODE_25: begin
                    cl_tap <= 2'h0;
                    cl_half <= 1'b1;
                end
                `DDF_CL_CODE_3: begin
                    cl_tap <= 2'h1;
                    cl_half <= 1'b0;
                end
                `DDF_CL_CODE_4: begin
                    cl_tap <= 2'h2;
                    cl_half <= 1'b0;
                end
                default: cl_tap <= cl_tap;
            endcase
        end
    end

    // Auto refresh walks the row counter
    always_ff @(posedge ck) begin
        if (ck_rst) begin
            auto_ref_row <= '0;
        end else if (accept && cmd == DDF_CMD_REF) begin
            auto_ref_row <= auto_ref_row + 1'b1;
        end
    end

    // Burst engine: one two-beat word per link clock
    logic bst_rd;
    logic [1:0] bst_left;
    logic [1:0] bst_j;
    ddf_bank_type bst_bank;
    logic [CW-1:0] bst_col;
    logic start_rd;
    logic start_wr;
    logic cont;
    logic issue_rd;
    logic issue_wr;
    ddf_bank_type cur_bank;
    logic [CW-1:0] cur_col;
    logic [1:0] cur_j;
    logic [ROW_W-1:0] cur_row;
    logic [AW-1:0] word_addr;

    assign start_rd = accept && cmd == DDF_CMD_READ && bank_open[ba];
    assign start_wr = accept && cmd == DDF_CMD_WRITE && bank_open[ba];
    // Bursts freeze while enable is low; the controller must not allow it
    assign cont = (bst_left != 2'h0) && cke;
    assign issue_rd = start_rd || (cont && bst_rd);
    assign issue_wr = start_wr || (cont && !bst_rd);
    assign cur_bank = (start_rd || start_wr) ? ba : bst_bank;
    assign cur_col = (start_rd || start_wr) ? addr[COL_W-1:1] : bst_col;
    assign cur_j = (start_rd || start_wr) ? 2'h0 : bst_j;
    assign cur_row = bank_row[cur_bank];
    assign word_addr = {cur_bank, cur_row[ROW_KEEP-1:0], cur_col[CW-1:2],
        ddf_burst_word(cur_col[1:0], cur_j, bl_words, il)};

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            bst_rd <= 1'b0;
            bst_left <= 2'h0;
            bst_j <= 2'h0;
            bst_bank <= 2'h0;
            bst_col <= '0;
        end else if (start_rd || start_wr) begin
            bst_rd <= start_rd;
            bst_left <= 2'(bl_words - 3'h1);
            bst_j <= 2'h1;
            bst_bank <= ba;
            bst_col <= addr[COL_W-1:1];
        end else if (accept && cmd == DDF_CMD_STOP && bst_rd) begin
            bst_left <= 2'h0;
        end else if (cont) begin
            bst_left <= bst_left - 2'h1;
            bst_j <= bst_j + 2'h1;
        end
    end

    // Write capture: beat 0 on the rising edge, beat 1 on the falling one
    logic wa_v;
    logic [AW-1:0] wa_addr;
    logic wb_v;
    logic [AW-1:0] wb_addr;
    logic [DQ_W-1:0] w_lo;
    logic [DQ_W-1:0] w_hi;
    logic [LANES-1:0] m_lo;
    logic [LANES-1:0] m_hi;
    logic [LANES-1:0] s_lo;
    logic [LANES-1:0] s_hi;

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            wa_v <= 1'b0;
            wb_v <= 1'b0;
            wa_addr <= '0;
            wb_addr <= '0;
        end else begin
            wa_v <= issue_wr;
            wa_addr <= word_addr;
            wb_v <= wa_v;
            wb_addr <= wa_addr;
        end
    end

    // Chip select does not gate data, mask or strobe capture
    always_ff @(posedge ck) begin
        w_lo <= dq_in;
        m_lo <= dm;
        s_lo <= dqs_in;
    end

    always_ff @(negedge ck) begin
        w_hi <= dq_in;
        m_hi <= dm;
        s_hi <= dqs_in;
    end

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            wr_dqs_toggle <= '0;
        end else if (wb_v) begin
            wr_dqs_toggle <= s_lo ^ s_hi;
        end
    end

    // Storage
    logic rd_issue_q;
    logic [2*DQ_W-1:0] rd_data;

    ddf_mem #(
        .AW(AW),
        .LANES(2 * LANES)
    ) u_mem (
        .clk(ck),
        .wr_en(wb_v),
        .wr_addr(wb_addr),
        .wr_data({w_hi, w_lo}),
        .wr_be(~{m_hi, m_lo}),
        .rd_en(issue_rd),
        .rd_addr(word_addr),
        .rd_data(rd_data)
    );

    // Read latency line, tapped by the selected latency
    logic dly_v [0:DLY-1];
    logic [2*DQ_W-1:0] dly_w [0:DLY-1];
    logic tap_v;
    logic [2*DQ_W-1:0] tap_w;

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            rd_issue_q <= 1'b0;
            for (int k = 0; k < DLY; k++) begin
                dly_v[k] <= 1'b0;
                dly_w[k] <= '0;
            end
        end else begin
            rd_issue_q <= issue_rd;
            dly_v[0] <= rd_issue_q;
            dly_w[0] <= rd_data;
            for (int k = 1; k < DLY; k++) begin
                dly_v[k] <= dly_v[k-1];
                dly_w[k] <= dly_w[k-1];
            end
        end
    end

    assign tap_v = dly_v[cl_tap];
    assign tap_w = dly_w[cl_tap];

    // Output beats; half latency moves the first beat to the falling edge
    logic cur_v;
    logic [2*DQ_W-1:0] cur_w;
    logic rise_v;
    logic [DQ_W-1:0] rise_d;
    logic fall_v;
    logic [DQ_W-1:0] fall_d;
    logic drive;

    always_ff @(posedge ck) begin
        if (ck_rst) begin
            cur_v <= 1'b0;
            cur_w <= '0;
            rise_v <= 1'b0;
            rise_d <= '0;
        end else begin
            cur_v <= tap_v;
            cur_w <= tap_w;
            rise_v <= cl_half ? cur_v : tap_v;
            rise_d <= cl_half ? cur_w[2*DQ_W-1:DQ_W] : tap_w[DQ_W-1:0];
        end
    end

    always_ff @(negedge ck) begin
        if (ck_rst) begin
            fall_v <= 1'b0;
            fall_d <= '0;
        end else begin
            fall_v <= cur_v;
            fall_d <= cl_half ? cur_w[DQ_W-1:0] : cur_w[2*DQ_W-1:DQ_W];
        end
    end

    // Selecting by clock level puts every transition on a clock transition
    assign dq_out = ck ? rise_d : fall_d;
    assign drive = (ck ? rise_v : fall_v) && cke;
    assign dq_oe_n = !drive;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_strobe
            assign dqs_out[g] = ck;
            assign dqs_oe_n[g] = !drive;
        end
    endgenerate

    // Self refresh timing on the system clock: the link clock may stop
    logic sref_meta;
    logic sref_s;
    logic cke_meta;
    logic cke_s;
    logic [TW-1:0] ref_timer;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sref_meta <= 1'b0;
            sref_s <= 1'b0;
            cke_meta <= 1'b1;
            cke_s <= 1'b1;
        end else begin
            sref_meta <= sref_flag;
            sref_s <= sref_meta;
            cke_meta <= cke;
            cke_s <= cke_meta;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || !sref_s || cke_s) begin
            ref_timer <= '0;
            sref_refresh <= 1'b0;
        end else if (ref_timer == TW'(REF_CNT - 1)) begin
            ref_timer <= '0;
            sref_refresh <= 1'b1;
        end else begin
            ref_timer <= ref_timer + 1'b1;
            sref_refresh <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sref_row <= '0;
        end else if (sref_refresh) begin
            sref_row <= sref_row + 1'b1;
        end
    end

endmodule : ddf_frontend

// file: verification/ddf_frontend_chk.sv
// Port assertions for the memory front end
`timescale 1ns/1ns
`include "ddf_regs.svh"
module ddf_frontend_chk
    import ddf_pkg::*;
#(
    parameter int DQ_W = 8
) (
    // Clocks and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ck,
    // Link command
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire ddf_pkg::ddf_bank_type ba,
    // Watched outputs
    input wire logic dq_oe_n,
    input wire logic [DQ_W/8-1:0] dqs_out,
    input wire ddf_pkg::ddf_pwr_type power_state,
    input wire logic self_refresh,
    input wire logic [3:0] bank_open,
    input wire logic [`DDF_REF_ROW_W-1:0] auto_ref_row,
    input wire logic sref_refresh
);
    localparam int LN = DQ_W / 8;
    logic seen;
    logic [11:0] gap;
    logic act_cmd;
    logic ref_cmd;
    assign act_cmd = !cs_n && !ras_n && cas_n && we_n;
    assign ref_cmd = !cs_n && !ras_n && !cas_n && we_n;

    // Gap is only meaningful between two pulses of one stay in self refresh
    always_ff @(posedge mclk) begin
        if (sys_rst || cke) begin
            seen <= 1'b0;
            gap <= 12'h000;
        end else if (sref_refresh) begin
            seen <= 1'b1;
            gap <= 12'h000;
        end else begin
            gap <= gap + 12'h001;
        end
    end

    sref_gap_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sref_refresh && seen |-> gap == 12'(`DDF_REF_INTERVAL_CYC - 1))
        else $error("self refresh spacing wrong");
    oe_cke_a: assert property (
        @(posedge mclk) disable iff (sys_rst) !cke |-> dq_oe_n)
        else $error("driving while clock enable low");
    sref_exit_a: assert property (
        @(posedge mclk) disable iff (sys_rst) cke |-> !self_refresh)
        else $error("self refresh flag outlives enable");
    strobe_ck_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !dq_oe_n |-> dqs_out == {LN{ck}})
        else $error("strobe not following clock");
    act_open_a: assert property (
        @(posedge ck) disable iff (sys_rst)
        act_cmd && cke && $past(cke) && power_state == DDF_PWR_ON
        |=> bank_open[$past(ba)])
        else $error("activate left bank closed");
    cs_mask_a: assert property (
        @(posedge ck) disable iff (sys_rst) cs_n |=> $stable(bank_open))
        else $error("deselected command acted");
    ref_count_a: assert property (
        @(posedge ck) disable iff (sys_rst)
        ref_cmd && cke && $past(cke) && power_state == DDF_PWR_ON
        |=> auto_ref_row - $past(auto_ref_row) == 13'h0001)
        else $error("refresh row not advanced");
    sref_in_a: assert property (
        @(posedge ck) disable iff (sys_rst)
        ref_cmd && !cke && $past(cke) && power_state == DDF_PWR_ON
        && bank_open == 4'h0 |=> power_state == DDF_PWR_SREF)
        else $error("self refresh not entered");
    pdn_act_a: assert property (
        @(posedge ck) disable iff (sys_rst)
        !cke && $past(cke) && power_state == DDF_PWR_ON
        && bank_open != 4'h0 |=> power_state == DDF_PWR_PDN_ACT)
        else $error("active power-down not entered");
    pdn_exit_a: assert property (
        @(posedge ck) disable iff (sys_rst)
        (power_state == DDF_PWR_PDN_PRE || power_state == DDF_PWR_PDN_ACT)
        && cke |=> power_state == DDF_PWR_ON)
        else $error("power-down exit missed");

    sref_c: cover property (@(posedge mclk) sref_refresh);
    pdn_c: cover property (@(posedge ck) power_state == DDF_PWR_PDN_ACT);
    read_c: cover property (@(posedge mclk) !dq_oe_n);
endmodule : ddf_frontend_chk

bind ddf_frontend ddf_frontend_chk #(.DQ_W(DQ_W)) u_chk (
    .mclk, .sys_rst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .dq_oe_n,
    .dqs_out, .power_state, .self_refresh, .bank_open, .auto_ref_row,
    .sref_refresh
);

// file: verification/ddf_host_model.sv
// Behavioural memory controller on the link side
`timescale 1ns/1ns
module ddf_host_model (
    // Link clock and command
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    // Write data
    output logic [7:0] dq_in,
    output logic dqs_in,
    output logic dm
);
    // Offset by 1 ns so link edges never meet system clock edges
    initial begin
        ck = 1'b0;
        #1;
        forever #40 ck = ~ck;
    end
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        ba = 2'h0;
        addr = 13'h0000;
        dq_in = 8'hA5;
        dqs_in = 1'b0;
        dm = 1'b1;
    end

    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
        input logic [12:0] a);
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        ba <= ~b;
        addr <= ~a;
    endtask : cmd

    task automatic set_cke(input logic v);
        @(negedge ck);
        cke <= v;
    endtask : set_cke

    // Beats change a quarter clock before their edge, centred on it
    task automatic wr(input logic [12:0] a, input logic [63:0] d,
        input logic [7:0] m, input int n);
        cmd(4'h4, 2'h1, a);
        #20;
        for (int k = 0; k < n; k++) begin
            dq_in <= d[8*k +: 8];
            dm <= m[k];
            dqs_in <= ~k[0];
            #40;
        end
        dq_in <= ~dq_in;
        dm <= ~dm;
        dqs_in <= ~dqs_in;
        repeat (2) @(negedge ck);
    endtask : wr
endmodule : ddf_host_model

// file: verification/tb_top.sv
// Self-checking bench for the memory front end
`timescale 1ns/1ns
module tb_top;
    import ddf_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ck, cke, cs_n, ras_n, cas_n, we_n, dm, dqs_in, dqs_out, dqs_oe_n;
    logic dq_oe_n, self_refresh, sref_refresh, wr_dqs_toggle;
    logic [1:0] ba;
    logic [12:0] addr, auto_ref_row, sref_row, r;
    logic [7:0] dq_in, dq_out;
    logic [7:0] exp_mem [0:7];
    logic [3:0] bank_open;
    ddf_pwr_type power_state;
    logic [12:0] md [0:6] = '{13'h023, 13'h02B, 13'h022, 13'h021, 13'h062,
        13'h032, 13'h042};
    int clh [0:6] = '{4, 4, 4, 4, 5, 6, 8};
    int bl [0:6] = '{8, 8, 4, 2, 4, 4, 4};
    int failures = 0;
    int tests_run = 0;
    int n = 0;

    ddf_frontend #(.DQ_W(8)) DUT (
        .mclk, .sys_rst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .dq_in, .dq_out, .dq_oe_n, .dqs_in, .dqs_out, .dqs_oe_n, .dm,
        .power_state, .self_refresh, .bank_open, .auto_ref_row,
        .wr_dqs_toggle, .sref_refresh, .sref_row
    );
    ddf_host_model host (
        .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in,
        .dqs_in, .dm
    );

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Samples each half clock a quarter period after its edge
    task automatic rd(input int col, ch, nb, input logic il);
        int k;
        int w;
        host.cmd(4'h5, 2'h1, 13'(col));
        for (int h = 1; h <= ch + nb; h++) begin
            #20;
            k = h - ch;
            w = il ? (col / 2) ^ (k / 2) : (col / 2 + k / 2) % (nb / 2);
            if (k >= 0 && k < nb) begin
                check(dq_out, exp_mem[2 * w + k % 2]);
                check(dqs_out, ck);
            end
            check(dq_oe_n, !(k >= 0 && k < nb));
            #20;
        end
    endtask : rd

    initial begin
        repeat (6) @(negedge ck);
        @(negedge mclk);
        sys_rst = 1'b0;
        check(dq_oe_n, 1'b1);
        check(power_state, DDF_PWR_ON);
        repeat (3) @(negedge ck);
        host.cmd(4'h3, 2'h1, 13'h0000);
        check(bank_open, 4'h2);
        host.cmd(4'hB, 2'h2, 13'h0000);
        check(bank_open, 4'h2);
        host.cmd(4'h3, 2'h0, 13'h0000);
        host.cmd(4'h3, 2'h3, 13'h0000);
        host.cmd(4'h2, 2'h3, 13'h0000);
        check(bank_open, 4'h3);
        host.cmd(4'h0, 2'h0, 13'h0023);
        host.wr(13'h0000, 64'h1716151413121110, 8'h00, 8);
        check(wr_dqs_toggle, 1'b1);
        host.wr(13'h0000, 64'hA7A6A5A4A3A2A1A0, 8'h04, 8);
        for (int k = 0; k < 8; k++) begin
            exp_mem[k] = (k == 2) ? 8'h12 : 8'(8'hA0 + k);
        end
        for (int i = 0; i < 7; i++) begin
            host.cmd(4'h0, 2'h0, md[i]);
            host.cmd(4'h0, 2'(i % 3 + 1), 13'h0041);
            rd(bl[i] == 8 ? 6 : 0, clh[i], bl[i], md[i][3]);
        end
        host.cmd(4'h3, 2'h2, 13'h0000);
        host.set_cke(1'b0);
        @(negedge ck);
        check(power_state, DDF_PWR_PDN_ACT);
        host.set_cke(1'b1);
        @(negedge ck);
        check(power_state, DDF_PWR_ON);
        host.cmd(4'h2, 2'h0, 13'h0400);
        check(bank_open, 4'h0);
        host.set_cke(1'b0);
        @(negedge ck);
        check(power_state, DDF_PWR_PDN_PRE);
        host.cmd(4'h3, 2'h0, 13'h0000);
        check(bank_open, 4'h0);
        host.set_cke(1'b1);
        @(negedge ck);
        r = auto_ref_row;
        host.cmd(4'h1, 2'h0, 13'h0000);
        check(auto_ref_row, r + 13'h0001);
        fork
            host.cmd(4'h1, 2'h0, 13'h0000);
            host.set_cke(1'b0);
        join
        check(power_state, DDF_PWR_SREF);
        check(self_refresh, 1'b1);
        host.cmd(4'h3, 2'h0, 13'h0000);
        check(bank_open, 4'h0);
        for (int i = 0; i < 5000 && n < 2; i++) begin
            @(negedge mclk);
            n += int'(sref_refresh);
        end
        check(16'(n), 16'h0002);
        // Row count steps one system clock after the pulse
        @(negedge mclk);
        check(sref_row, 13'h0002);
        // Rise mid-cycle so only an asynchronous path can clear the flag
        @(negedge ck);
        @(negedge mclk);
        host.cke <= 1'b1;
        @(posedge mclk);
        check(self_refresh, 1'b0);
        repeat (2) @(negedge ck);
        check(power_state, DDF_PWR_ON);
        complete_run();
    end
endmodule : tb_top
